// File: logic/adc_gcfg_regs.svh
// Operation
// - reset clears whole register, converter off
// - bus master reads and writes register
// - disabled: clocks stopped, analog in low power
// - disabled: other converter register writes ignored
// - clearing enable restarts machine, drops trigger
// - enabled: clocks run, analog powered up
// - converter usable within settling time
// - input source: multiplexer or dedicated pin
// - differential bit picks single or differential
// - analog setup from mode and channel
// - pen detect code enables detector, ORs wakeup
// - interrupt enable gates data valid request
// - monitor enable drives one or both outputs
`ifndef ADC_GCFG_REGS_SVH
`define ADC_GCFG_REGS_SVH
`define ADC_GCFG_WIDTH 16
`define ADC_GCFG_RESET 16'h0000
`define ADC_GCFG_RSVD_MASK 16'hdfff
`define ADC_TOUCH_PEN_DETECT 3'h5
`define ADC_CLK_PERIOD_NS 10
`define ADC_SETTLE_NS 250
`define ADC_SETTLE_CYC (`ADC_SETTLE_NS / `ADC_CLK_PERIOD_NS)
// off exit step, settle exit step and ready flop take three cycles of the budget
`define ADC_SETTLE_LAG 3
`define ADC_SETTLE_CNT_W 5
`endif

// File: logic/adc_gcfg_pkg.sv
`default_nettype none
package adc_gcfg_pkg;
    // register image, msb first
    typedef struct packed {
        logic monitorOutputEnable;
        logic interruptEnable;
        logic reserved;
        logic [1:0] negativeRefSelect;
        logic [1:0] positiveRefSelect;
        logic [2:0] touchDriverConfig;
        logic [2:0] channelSelect;
        logic differentialMode;
        logic inputSourceSelect;
        logic converterEnable;
    } adc_global_config_t;
    typedef enum logic [2:0] {
        ST_OFF = 3'h1,
        ST_SETTLE = 3'h2,
        ST_READY = 3'h4
    } power_state_t;
endpackage
`default_nettype wire

// File: logic/adc_global_configuration.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_gcfg_regs.svh"
module adc_global_configuration (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cfgWrite,
    input wire logic cfgRead,
    input wire logic [15:0] cfgWrData,
    output logic [15:0] cfgRdData,
    input wire logic otherWrReq,
    output logic otherWrAllow,
    input wire logic convDone,
    input wire logic resultValid,
    input wire logic penDownPin,
    output var adc_gcfg_pkg::adc_global_config_t analogCfg,
    output logic converterClockEn,
    output logic analogPowerUp,
    output logic converterReady,
    output logic smRestart,
    output logic triggerCancel,
    output logic penDetectEnable,
    output logic converterWakeup,
    output logic converterIrq,
    output logic monitorOutAEn,
    output logic monitorOutBEn
);
    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    adc_gcfg_pkg::adc_global_config_t cfg_q;
    adc_gcfg_pkg::power_state_t state_q;
    logic [`ADC_SETTLE_CNT_W-1:0] settleCnt_q;
    logic penSync1_q;
    logic penSync2_q;
    logic [`ADC_SETTLE_CNT_W-1:0] watchCnt_q;
    adc_gcfg_pkg::adc_global_config_t wrImage;

    // write data seen through the register layout, so no bit index is spelled out
    assign wrImage = cfgWrData;

    // reserved bit never stores, so it always reads zero
    always_ff @(posedge clk)
    begin
        if (!resetn)
            cfg_q <= `ADC_GCFG_RESET;
        else if (cfgWrite)
            cfg_q <= cfgWrData & `ADC_GCFG_RSVD_MASK;
    end

    // read data cleared on an edge where the read strobe is low, so it is zero the cycle after
    always_ff @(posedge clk)
    begin
        if (!resetn)
            cfgRdData <= `ADC_GCFG_RESET;
        else if (cfgRead)
            cfgRdData <= cfg_q;
        else
            cfgRdData <= `ADC_GCFG_RESET;
    end

    // ----------------------------------------
    // power, clocks and settling
    // ----------------------------------------
    // settle count runs from the enable; a disable aborts it at once
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q <= adc_gcfg_pkg::ST_OFF;
            settleCnt_q <= '0;
        end
        else
        begin
            case (state_q)
                adc_gcfg_pkg::ST_OFF:
                begin
                    settleCnt_q <= '0;
                    if (cfg_q.converterEnable)
                        state_q <= adc_gcfg_pkg::ST_SETTLE;
                end
                adc_gcfg_pkg::ST_SETTLE:
                begin
                    settleCnt_q <= settleCnt_q + 1'b1;
                    if (!cfg_q.converterEnable)
                        state_q <= adc_gcfg_pkg::ST_OFF;
                    else if (settleCnt_q ==
                             `ADC_SETTLE_CNT_W'(`ADC_SETTLE_CYC - `ADC_SETTLE_LAG))
                        state_q <= adc_gcfg_pkg::ST_READY;
                end
                adc_gcfg_pkg::ST_READY:
                begin
                    if (!cfg_q.converterEnable)
                        state_q <= adc_gcfg_pkg::ST_OFF;
                end
                default:
                    state_q <= adc_gcfg_pkg::ST_OFF;
            endcase
        end
    end

    // clocks and analog power follow the enable bit
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            converterClockEn <= 1'b0;
            analogPowerUp <= 1'b0;
            converterReady <= 1'b0;
        end
        else
        begin
            converterClockEn <= cfg_q.converterEnable;
            analogPowerUp <= cfg_q.converterEnable;
            converterReady <= cfg_q.converterEnable &&
                              (state_q == adc_gcfg_pkg::ST_READY);
        end
    end

    // restart pulse on a write that clears a set enable bit
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            smRestart <= 1'b0;
            triggerCancel <= 1'b0;
        end
        else
        begin
            smRestart <= cfgWrite && cfg_q.converterEnable && !wrImage.converterEnable;
            triggerCancel <= cfgWrite && cfg_q.converterEnable &&
                             !wrImage.converterEnable;
        end
    end

    // other registers lock while disabled; aux config is not routed here
    always_ff @(posedge clk)
    begin
        if (!resetn)
            otherWrAllow <= 1'b0;
        else
            otherWrAllow <= otherWrReq && cfg_q.converterEnable;
    end

    // ----------------------------------------
    // analog setup and side outputs
    // ----------------------------------------
    // analog fields pass through one flop so the outputs are registered
    always_ff @(posedge clk)
    begin
        if (!resetn)
            analogCfg <= `ADC_GCFG_RESET;
        else
            analogCfg <= cfg_q;
    end

    // pen detector is asynchronous, so it is synchronised first
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            penSync1_q <= 1'b0;
            penSync2_q <= 1'b0;
        end
        else
        begin
            penSync1_q <= penDownPin;
            penSync2_q <= penSync1_q;
        end
    end

    // wakeup ignores the interrupt enable; irq is gated by it
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            penDetectEnable <= 1'b0;
            converterWakeup <= 1'b0;
            converterIrq <= 1'b0;
        end
        else
        begin
            penDetectEnable <= (cfg_q.touchDriverConfig == `ADC_TOUCH_PEN_DETECT);
            converterWakeup <= convDone || (penSync2_q &&
                (cfg_q.touchDriverConfig == `ADC_TOUCH_PEN_DETECT));
            converterIrq <= cfg_q.interruptEnable && resultValid;
        end
    end

    // monitor b only in differential mode
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            monitorOutAEn <= 1'b0;
            monitorOutBEn <= 1'b0;
        end
        else
        begin
            monitorOutAEn <= cfg_q.monitorOutputEnable;
            monitorOutBEn <= cfg_q.monitorOutputEnable && cfg_q.differentialMode;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // cycles of unbroken enable; saturates so a long enabled run never wraps to zero
    always_ff @(posedge clk)
    begin
        if (!resetn)
            watchCnt_q <= '0;
        else if (!cfg_q.converterEnable)
            watchCnt_q <= '0;
        else if (watchCnt_q != '1)
            watchCnt_q <= watchCnt_q + 1'b1;
    end

    a_reset_clears: assert property (@(posedge clk)
        !resetn |=> cfg_q == `ADC_GCFG_RESET)
        else $error("config not cleared by reset");
    a_write_stores: assert property (@(posedge clk) disable iff (!resetn)
        cfgWrite ##1 cfgRead |=> cfgRdData == ($past(cfgWrData, 2) & `ADC_GCFG_RSVD_MASK))
        else $error("written value not read back");
    a_clock_gated: assert property (@(posedge clk) disable iff (!resetn)
        !cfg_q.converterEnable |=> !converterClockEn && !analogPowerUp)
        else $error("clocks run while disabled");
    a_clock_runs: assert property (@(posedge clk) disable iff (!resetn)
        cfg_q.converterEnable |=> converterClockEn && analogPowerUp)
        else $error("clocks stopped while enabled");
    a_write_lock: assert property (@(posedge clk) disable iff (!resetn)
        otherWrReq && !cfg_q.converterEnable |=> !otherWrAllow)
        else $error("write passed while disabled");
    a_restart_pulse: assert property (@(posedge clk) disable iff (!resetn)
        $fell(cfg_q.converterEnable) |-> smRestart && triggerCancel)
        else $error("no restart on disable");
    a_settle_time: assert property (@(posedge clk) disable iff (!resetn)
        cfg_q.converterEnable && (watchCnt_q >= `ADC_SETTLE_CNT_W'(`ADC_SETTLE_CYC))
        |-> converterReady)
        else $error("not ready after settle time");
    a_ready_settled: assert property (@(posedge clk) disable iff (!resetn)
        converterReady |-> watchCnt_q >= `ADC_SETTLE_CNT_W'(`ADC_SETTLE_CYC))
        else $error("ready before settle time");
    a_not_early: assert property (@(posedge clk) disable iff (!resetn)
        $rose(cfg_q.converterEnable) |-> !converterReady [*8])
        else $error("ready too early");
    a_analog_follow: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> analogCfg == $past(cfg_q))
        else $error("analog setup lags");
    a_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
        converterIrq |-> $past(cfg_q.interruptEnable) && $past(resultValid))
        else $error("irq without enable and data");
    a_wake_done: assert property (@(posedge clk) disable iff (!resetn)
        convDone |=> converterWakeup)
        else $error("done did not wake");
    a_monitor_b: assert property (@(posedge clk) disable iff (!resetn)
        monitorOutBEn |-> monitorOutAEn && $past(cfg_q.differentialMode))
        else $error("monitor b outside differential");
    c_enable_ready: cover property (@(posedge clk) disable iff (!resetn)
        $rose(cfg_q.converterEnable) ##[1:30] converterReady);
    c_disable: cover property (@(posedge clk) disable iff (!resetn) smRestart);
    c_pen_wake: cover property (@(posedge clk) disable iff (!resetn)
        penDetectEnable && converterWakeup && !convDone);
endmodule // adc_global_configuration
`default_nettype wire

// File: testbench/adc_global_configuration_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_global_configuration_tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk, resetn, cfgWrite, cfgRead, otherWrReq, convDone, resultValid, penDownPin;
    logic [15:0] cfgWrData, cfgRdData, wrVal;
    logic otherWrAllow, converterClockEn, analogPowerUp, converterReady, smRestart;
    logic triggerCancel, penDetectEnable, converterWakeup, converterIrq;
    logic monitorOutAEn, monitorOutBEn, rdLag;
    adc_gcfg_pkg::adc_global_config_t analogCfg;
    logic [15:0] expQ[$];
    int errCount, checks, seed;

    adc_global_configuration u_dut (
        .clk(clk), .resetn(resetn), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
        .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .otherWrReq(otherWrReq),
        .otherWrAllow(otherWrAllow), .convDone(convDone), .resultValid(resultValid),
        .penDownPin(penDownPin), .analogCfg(analogCfg), .converterClockEn(converterClockEn),
        .analogPowerUp(analogPowerUp), .converterReady(converterReady),
        .smRestart(smRestart), .triggerCancel(triggerCancel),
        .penDetectEnable(penDetectEnable), .converterWakeup(converterWakeup),
        .converterIrq(converterIrq), .monitorOutAEn(monitorOutAEn),
        .monitorOutBEn(monitorOutBEn)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // inputs move 1 ns after the edge so the design never races the bench
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [15:0] d);
        cfgWrite = 1'b1;
        cfgWrData = d;
        tick(1);
        cfgWrite = 1'b0;
    endtask

    // the expected word is queued before the strobe so the monitor always finds it
    task automatic rd(input logic [15:0] exp);
        expQ.push_back(exp);
        cfgRead = 1'b1;
        tick(1);
        cfgRead = 1'b0;
    endtask

    // ----------------------------------------
    // clock, monitor, watchdog
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // read data stands for one cycle only, so it is taken on the falling edge after the read
    initial
    begin
        rdLag = 1'b0;
        forever
        begin
            @(negedge clk);
            if (rdLag)
            begin
                if (expQ.size() == 0)
                    check("unexpected read", cfgRdData, 16'hxxxx);
                else
                    check("cfgRdData", cfgRdData, expQ.pop_front());
            end
            rdLag = cfgRead;
        end
    end

    initial
    begin
        #200000;
        errCount++;
        end_of_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        {resetn, cfgWrite, cfgRead, otherWrReq, convDone, resultValid, penDownPin} = '0;
        cfgWrData = 16'h0000;
        errCount = 0;
        checks = 0;
        seed = 55;
        tick(4);
        resetn = 1'b1;
        check("outputs", {converterClockEn, analogPowerUp, converterReady, smRestart,
            triggerCancel, penDetectEnable, converterWakeup, converterIrq, monitorOutAEn,
            monitorOutBEn}, 16'h0000);
        rd(16'h0000);
        // random words, read back at once; the reserved bit never sticks
        repeat (8)
        begin
            wrVal = 16'($random(seed));
            wr(wrVal);
            rd(wrVal & 16'hdfff);
        end
        wr(16'h0000);
        tick(1);
        check("clock power off", {converterClockEn, analogPowerUp}, 16'h0000);
        otherWrReq = 1'b1;
        tick(1);
        check("lock off", otherWrAllow, 16'h0000);
        otherWrReq = 1'b0;
        wr(16'h0001);
        tick(24);
        check("clock power on", {converterClockEn, analogPowerUp}, 16'h0003);
        check("ready early", converterReady, 16'h0000);
        tick(1);
        check("ready", converterReady, 16'h0001);
        otherWrReq = 1'b1;
        tick(1);
        check("lock on", otherWrAllow, 16'h0001);
        otherWrReq = 1'b0;
        wr(16'h0000);
        check("restart", {smRestart, triggerCancel}, 16'h0003);
        tick(1);
        check("restart end", {smRestart, triggerCancel}, 16'h0000);
        check("disabled", {converterClockEn, analogPowerUp, converterReady}, 16'h0000);
        // pen detect code, differential, channel 3, irq and monitor on
        wr(16'hc15f);
        tick(1);
        check("analogCfg", analogCfg, 16'hc15f);
        check("pen detect", penDetectEnable, 16'h0001);
        check("monitor differential_mode", {monitorOutAEn, monitorOutBEn}, 16'h0003);
        check("irq idle", converterIrq, 16'h0000);
        resultValid = 1'b1;
        penDownPin = 1'b1;
        tick(4);
        check("irq", converterIrq, 16'h0001);
        check("wakeup pen", converterWakeup, 16'h0001);
        resultValid = 1'b0;
        wr(16'h4002);
        tick(4);
        check("analogCfg src", analogCfg, 16'h4002);
        check("wakeup no pen", converterWakeup, 16'h0000);
        check("monitor off", {monitorOutAEn, monitorOutBEn}, 16'h0000);
        convDone = 1'b1;
        tick(1);
        check("wakeup done", converterWakeup, 16'h0001);
        convDone = 1'b0;
        wr(16'h8000);
        tick(1);
        check("monitor single", {monitorOutAEn, monitorOutBEn}, 16'h0002);
        check("single ended", analogCfg, 16'h8000);
        tick(2);
        check("reads left", 16'(expQ.size()), 16'h0000);
        end_of_test();
    end
endmodule // adc_global_configuration_tb
`default_nettype wire
